// ### src/rtcw_pkg.sv
// constants, types and helpers shared by the rtc register window block
//
// Contract
// - two-bit time pointer at config bits 9-8 picks the time window pair
// - time pointer 0 min/sec, 1 weekday/hours, 2 month/day, 3 zero/year
// - time window high-byte write lowers time pointer, stopping at zero
// - at pointer zero the time window keeps showing minutes and seconds
// - alarm pointer picks alarm pair: min/sec, weekday/hours, month/day, none
// - alarm window high-byte write lowers alarm pointer, stopping at zero
// - any read of either window byte lowers that window's pointer
// - low-byte writes never move a window pointer
// - time window writes are dropped unless the unlock bit 13 is set
// - unlock bit may be set only just after key writes 55h then aah
// - two-bit source field picks crystal, low-power osc, 50 hz or 60 hz
// - module enable bit 15 is writable only while unlock bit is set
// - read ripple flag bit 12 follows the counters' rollover hazard while module enable bit 15 is set, else reads zero
// - half-second flag bit 11 is read-only, cleared by min/sec low write
// - output enable bit 10 turns the clock output function on
// - config register is reset only by power-on reset
// - signed eight-bit trim adds or removes pulses every 15 seconds
// - source select sits at bits 11-10 of the power control register
package rtcw_pkg;

	localparam int DATA_W = 16;
	localparam int ADDR_W = 3;
	localparam int PTR_W  = 2;
	localparam int TRIM_W = 8;
	localparam int BYTE_W = 8;

	// register indexes on the plain register port
	localparam logic [ADDR_W-1:0] ADDR_CFG   = 3'h0;
	localparam logic [ADDR_W-1:0] ADDR_TIME  = 3'h1;
	localparam logic [ADDR_W-1:0] ADDR_ALARM = 3'h2;
	localparam logic [ADDR_W-1:0] ADDR_ALSET = 3'h3;
	localparam logic [ADDR_W-1:0] ADDR_PWR   = 3'h4;
	localparam logic [ADDR_W-1:0] ADDR_KEY   = 3'h5;

	// clock_config_trim field layout
	localparam int CFG_ON_BIT     = 15;
	localparam int CFG_UNLOCK_BIT = 13;
	localparam int CFG_RIPPLE_BIT = 12;
	localparam int CFG_HALF_BIT   = 11;
	localparam int CFG_OE_BIT     = 10;
	localparam int PTR_LSB        = 8;
	localparam int TRIM_LSB       = 0;
	localparam int SRC_LSB        = 10;

	// reset values and implemented-bit masks
	localparam logic [DATA_W-1:0] CFG_RST   = 16'h0000;
	localparam logic [DATA_W-1:0] ALSET_RST = 16'h0000;
	localparam logic [DATA_W-1:0] PWR_RST   = 16'h0000;
	localparam logic [DATA_W-1:0] PWR_MASK  = 16'hff00;

	// window pointer values
	localparam logic [PTR_W-1:0] PTR_MINUTES_SECONDS_REGISTER = 2'h0;
	localparam logic [PTR_W-1:0] PTR_WDHR   = 2'h1;
	localparam logic [PTR_W-1:0] PTR_MTHDY  = 2'h2;
	localparam logic [PTR_W-1:0] PTR_TOP    = 2'h3;

	// reference source codes
	localparam logic [PTR_W-1:0] SRC_SEC_CRYSTAL = 2'h0;
	localparam logic [PTR_W-1:0] SRC_LOW_POWER   = 2'h1;
	localparam logic [PTR_W-1:0] SRC_LINE_50HZ   = 2'h2;
	localparam logic [PTR_W-1:0] SRC_LINE_60HZ   = 2'h3;

	// unlock key bytes
	localparam logic [BYTE_W-1:0] KEY_FIRST  = 8'h55;
	localparam logic [BYTE_W-1:0] KEY_SECOND = 8'haa;

	// unlock window: a longest time, so it rounds down, floor one cycle
	localparam int CLK_PERIOD_NS  = 10;
	localparam int UNLOCK_WIN_NS  = 20;
	localparam int UNLOCK_WIN_CYC = (UNLOCK_WIN_NS / CLK_PERIOD_NS) < 1 ?
		1 : (UNLOCK_WIN_NS / CLK_PERIOD_NS);
	localparam int WIN_CNT_W      = 4;

	typedef enum logic [2:0] {
		UL_IDLE = 3'b001,
		UL_HALF = 3'b010,
		UL_OPEN = 3'b100
	} rtcw_unlock_e;

	// saturating pointer step shared by both windows
	function automatic logic [PTR_W-1:0] ptr_step(input logic [PTR_W-1:0] p);
		ptr_step = (p == PTR_MINUTES_SECONDS_REGISTER) ? PTR_MINUTES_SECONDS_REGISTER : p - 2'h1;
	endfunction : ptr_step

endpackage : rtcw_pkg

// ### src/rtcw_unlock.sv
// key sequence watcher that opens a short window for the unlock bit
`timescale 1ns/1ps
module rtcw_unlock
	import rtcw_pkg::*;
#(
	parameter int WIN_CYC = UNLOCK_WIN_CYC
) (
	input  wire logic              sys_clk_i,
	input  wire logic              reset_n_i,
	input  wire logic              bus_act_i,
	input  wire logic              key_we_i,
	input  wire logic [BYTE_W-1:0] key_data_i,
	output logic                   open_o
);

	rtcw_unlock_e         state_q, state_d;
	logic [WIN_CNT_W-1:0] cnt_q, cnt_d;
	wire  logic           is_first  = key_we_i && key_data_i == KEY_FIRST;
	wire  logic           is_second = key_we_i && key_data_i == KEY_SECOND;

	// the second key must follow the first with no other access between
	always_comb begin
		state_d = state_q;
		cnt_d   = cnt_q;
		case (state_q)
			UL_IDLE: begin
				if (is_first) state_d = UL_HALF;
			end
			UL_HALF: begin
				if (is_second) begin
					state_d = UL_OPEN;
					cnt_d   = WIN_CNT_W'(WIN_CYC);
				end else if (is_first) begin
					state_d = UL_HALF;
				end else if (bus_act_i) begin
					state_d = UL_IDLE;
				end
			end
			UL_OPEN: begin
				// a repeated second key restarts the window
				if (is_second) begin
					cnt_d = WIN_CNT_W'(WIN_CYC);
				end else if (cnt_q <= WIN_CNT_W'(1)) begin
					state_d = UL_IDLE;
					cnt_d   = '0;
				end else begin
					cnt_d = cnt_q - WIN_CNT_W'(1);
				end
			end
			default: begin
				state_d = UL_IDLE;
				cnt_d   = '0;
			end
		endcase
	end

	always_ff @(posedge sys_clk_i) begin
		if (!reset_n_i) begin
			state_q <= UL_IDLE;
			cnt_q   <= '0;
		end else begin
			state_q <= state_d;
			cnt_q   <= cnt_d;
		end
	end

	assign open_o = (state_q == UL_OPEN);

endmodule : rtcw_unlock

// ### src/rtcw_pair_bank.sv
// indexed store of byte pairs behind one register window
`timescale 1ns/1ps
module rtcw_pair_bank
	import rtcw_pkg::*;
#(
	parameter int         SLOTS   = 4,
	parameter logic [3:0] HI_LIVE = 4'hf,
	parameter logic [3:0] LO_LIVE = 4'hf
) (
	input  wire logic              sys_clk_i,
	input  wire logic              reset_n_i,
	input  wire logic              sw_we_i,
	input  wire logic [1:0]        sw_be_i,
	input  wire logic [PTR_W-1:0]  sw_sel_i,
	input  wire logic [DATA_W-1:0] sw_data_i,
	input  wire logic              hw_we_i,
	input  wire logic [PTR_W-1:0]  hw_sel_i,
	input  wire logic [DATA_W-1:0] hw_data_i,
	input  wire logic [PTR_W-1:0]  rd_sel_i,
	output logic [DATA_W-1:0]      rd_data_o
);

	logic [DATA_W-1:0] slot_q [SLOTS];

	// dead bytes never store anything, so they read back as zero
	always_ff @(posedge sys_clk_i) begin
		for (int i = 0; i < SLOTS; i++) begin
			if (!reset_n_i) begin
				slot_q[i] <= '0;
			end else if (sw_we_i && sw_sel_i == PTR_W'(i)) begin
				if (sw_be_i[1] && HI_LIVE[i])
					slot_q[i][DATA_W-1:BYTE_W] <= sw_data_i[DATA_W-1:BYTE_W];
				if (sw_be_i[0] && LO_LIVE[i])
					slot_q[i][BYTE_W-1:0] <= sw_data_i[BYTE_W-1:0];
			end else if (hw_we_i && hw_sel_i == PTR_W'(i)) begin
				slot_q[i] <= hw_data_i & {{BYTE_W{HI_LIVE[i]}},
					{BYTE_W{LO_LIVE[i]}}};
			end
		end
	end

	assign rd_data_o = slot_q[rd_sel_i];

endmodule : rtcw_pair_bank

// ### src/rtcw_top.sv
// register front end of the rtc: windows, unlock, config and source select
//
// Strobed register access and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module rtcw_top
	import rtcw_pkg::*;
#(
	parameter int WIN_CYC = UNLOCK_WIN_CYC
) (
	input  wire logic              sys_clk_i,
	input  wire logic              reset_n_i,
	input  wire logic              other_reset_n_i,
	input  wire logic [ADDR_W-1:0] addr_i,
	input  wire logic [DATA_W-1:0] wdata_i,
	input  wire logic [1:0]        be_i,
	input  wire logic              wr_i,
	input  wire logic              rd_i,
	output logic [DATA_W-1:0]      rdata_o,
	input  wire logic              ripple_i,
	input  wire logic              half_tick_i,
	input  wire logic              time_upd_we_i,
	input  wire logic [PTR_W-1:0]  time_upd_sel_i,
	input  wire logic [DATA_W-1:0] time_upd_data_i,
	output logic                   module_on_o,
	output logic                   clock_output_on_o,
	output logic [PTR_W-1:0]       ref_source_o,
	output logic [TRIM_W-1:0]      drift_trim_o,
	output logic                   write_unlock_o,
	output logic                   prescaler_reset_o
);

	// config register pieces; all of them fall only to power-on reset
	logic               cfg_on_q;
	logic               cfg_unlock_q;
	logic               cfg_oe_q;
	logic [PTR_W-1:0]   time_ptr_q;
	logic [TRIM_W-1:0]  trim_q;
	logic               ripple_q;
	logic               half_q;

	// alarm setup and power control registers
	logic [DATA_W-1:0]  alset_q;
	logic [PTR_W-1:0]   alarm_ptr_q;
	logic [DATA_W-1:0]  pwr_q;

	logic [DATA_W-1:0]  rdata_q;
	logic               presc_rst_q;

	// next values
	logic               cfg_on_d;
	logic               cfg_unlock_d;
	logic               cfg_oe_d;
	logic [PTR_W-1:0]   time_ptr_d;
	logic [TRIM_W-1:0]  trim_d;
	logic               half_d;
	logic [DATA_W-1:0]  alset_d;
	logic [PTR_W-1:0]   alarm_ptr_d;
	logic [DATA_W-1:0]  pwr_d;
	logic [DATA_W-1:0]  rdata_d;

	logic               unlock_open;
	logic [DATA_W-1:0]  time_word;
	logic [DATA_W-1:0]  alarm_word;

	// address decode
	wire logic hit_cfg   = addr_i == ADDR_CFG;
	wire logic hit_time  = addr_i == ADDR_TIME;
	wire logic hit_alarm = addr_i == ADDR_ALARM;
	wire logic hit_alset = addr_i == ADDR_ALSET;
	wire logic hit_pwr   = addr_i == ADDR_PWR;
	wire logic hit_key   = addr_i == ADDR_KEY;

	wire logic wr_hi = wr_i && be_i[1];
	wire logic wr_lo = wr_i && be_i[0];

	// time window writes only pass while the lock is open
	wire logic time_wr_ok = wr_i && hit_time && cfg_unlock_q;
	wire logic alarm_wr   = wr_i && hit_alarm;

	// pointer movement: high-byte writes, or any read of the window
	wire logic time_step  = (time_wr_ok && be_i[1])
		|| (rd_i && hit_time);
	wire logic alarm_step = (alarm_wr && be_i[1])
		|| (rd_i && hit_alarm);

	// a low-byte write at the min/sec pair restarts the sub-second phase
	wire logic minutes_seconds_register_lo_wr = time_wr_ok && be_i[0]
		&& time_ptr_q == PTR_MINUTES_SECONDS_REGISTER;

	wire logic key_we = wr_lo && hit_key;

	// the unlock bit may only rise while the key window is open
	wire logic unlock_set = wr_hi && hit_cfg && wdata_i[CFG_UNLOCK_BIT]
		&& unlock_open;
	wire logic unlock_clr = wr_hi && hit_cfg && !wdata_i[CFG_UNLOCK_BIT];

	wire logic [DATA_W-1:0] cfg_word = {
		cfg_on_q, 1'b0, cfg_unlock_q, ripple_q, half_q, cfg_oe_q,
		time_ptr_q, trim_q};

	wire logic [DATA_W-1:0] alset_word = {
		alset_q[DATA_W-1:PTR_LSB+PTR_W], alarm_ptr_q,
		alset_q[PTR_LSB-1:0]};

	rtcw_unlock #(
		.WIN_CYC    (WIN_CYC)
	) u_unlock (
		.sys_clk_i  (sys_clk_i),
		.reset_n_i  (reset_n_i),
		.bus_act_i  (wr_i || rd_i),
		.key_we_i   (key_we),
		.key_data_i (wdata_i[BYTE_W-1:0]),
		.open_o     (unlock_open)
	);

	// time pairs; the top slot has no high byte
	rtcw_pair_bank #(
		.SLOTS     (4),
		.HI_LIVE   (4'h7),
		.LO_LIVE   (4'hf)
	) u_time_bank (
		.sys_clk_i (sys_clk_i),
		.reset_n_i (reset_n_i),
		.sw_we_i   (time_wr_ok),
		.sw_be_i   (be_i),
		.sw_sel_i  (time_ptr_q),
		.sw_data_i (wdata_i),
		.hw_we_i   (time_upd_we_i),
		.hw_sel_i  (time_upd_sel_i),
		.hw_data_i (time_upd_data_i),
		.rd_sel_i  (time_ptr_q),
		.rd_data_o (time_word)
	);

	// alarm pairs; the top slot is empty, counters never load alarms
	rtcw_pair_bank #(
		.SLOTS     (4),
		.HI_LIVE   (4'h7),
		.LO_LIVE   (4'h7)
	) u_alarm_bank (
		.sys_clk_i (sys_clk_i),
		.reset_n_i (reset_n_i),
		.sw_we_i   (alarm_wr),
		.sw_be_i   (be_i),
		.sw_sel_i  (alarm_ptr_q),
		.sw_data_i (wdata_i),
		.hw_we_i   (1'b0),
		.hw_sel_i  (PTR_MINUTES_SECONDS_REGISTER),
		.hw_data_i ('0),
		.rd_sel_i  (alarm_ptr_q),
		.rd_data_o (alarm_word)
	);

	// config register writes, split per byte lane
	assign cfg_on_d = (wr_hi && hit_cfg && cfg_unlock_q)
		? wdata_i[CFG_ON_BIT] : cfg_on_q;
	assign cfg_oe_d = (wr_hi && hit_cfg)
		? wdata_i[CFG_OE_BIT] : cfg_oe_q;
	assign cfg_unlock_d = unlock_set ? 1'b1
		: (unlock_clr ? 1'b0 : cfg_unlock_q);
	assign trim_d = (wr_lo && hit_cfg)
		? wdata_i[TRIM_LSB +: TRIM_W] : trim_q;

	// software sets the pointer directly, otherwise accesses step it down
	assign time_ptr_d = (wr_hi && hit_cfg)
		? wdata_i[PTR_LSB +: PTR_W]
		: (time_step ? ptr_step(time_ptr_q) : time_ptr_q);
	assign alarm_ptr_d = (wr_hi && hit_alset)
		? wdata_i[PTR_LSB +: PTR_W]
		: (alarm_step ? ptr_step(alarm_ptr_q) : alarm_ptr_q);

	// alarm setup and power control, pointer bits kept apart
	assign alset_d = {
		wr_hi && hit_alset ? wdata_i[DATA_W-1:BYTE_W] : alset_q[DATA_W-1:BYTE_W],
		wr_lo && hit_alset ? wdata_i[BYTE_W-1:0] : alset_q[BYTE_W-1:0]};
	assign pwr_d = (wr_hi && hit_pwr) ? (wdata_i & PWR_MASK) : pwr_q;

	// a half tick landing with the clear wins: the flag reads set
	assign half_d = minutes_seconds_register_lo_wr ? half_tick_i
		: (half_tick_i ? !half_q : half_q);

	// read mux; unmapped indexes and the key register read zero
	always_comb begin
		rdata_d = '0;
		if (rd_i) begin
			case (addr_i)
				ADDR_CFG:   rdata_d = cfg_word;
				ADDR_TIME:  rdata_d = time_word;
				ADDR_ALARM: rdata_d = alarm_word;
				ADDR_ALSET: rdata_d = alset_word;
				ADDR_PWR:   rdata_d = pwr_q;
				default:    rdata_d = '0;
			endcase
		end
	end

	// power-on reset only: other resets must not disturb the config word
	always_ff @(posedge sys_clk_i) begin
		if (!reset_n_i) begin
			cfg_on_q     <= CFG_RST[CFG_ON_BIT];
			cfg_unlock_q <= CFG_RST[CFG_UNLOCK_BIT];
			cfg_oe_q     <= CFG_RST[CFG_OE_BIT];
			time_ptr_q   <= CFG_RST[PTR_LSB +: PTR_W];
			trim_q       <= CFG_RST[TRIM_LSB +: TRIM_W];
			half_q       <= CFG_RST[CFG_HALF_BIT];
			ripple_q     <= CFG_RST[CFG_RIPPLE_BIT];
			pwr_q        <= PWR_RST;
		end else begin
			cfg_on_q     <= cfg_on_d;
			cfg_unlock_q <= cfg_unlock_d;
			cfg_oe_q     <= cfg_oe_d;
			time_ptr_q   <= time_ptr_d;
			trim_q       <= trim_d;
			half_q       <= half_d;
			ripple_q     <= ripple_i && cfg_on_q;
			pwr_q        <= pwr_d;
		end
	end

	// alarm setup falls to any reset source
	always_ff @(posedge sys_clk_i) begin
		if (!reset_n_i || !other_reset_n_i) begin
			alset_q     <= ALSET_RST;
			alarm_ptr_q <= ALSET_RST[PTR_LSB +: PTR_W];
		end else begin
			alset_q     <= alset_d;
			alarm_ptr_q <= alarm_ptr_d;
		end
	end

	// bus answer and registered outputs
	always_ff @(posedge sys_clk_i) begin
		if (!reset_n_i) begin
			rdata_q     <= '0;
			presc_rst_q <= 1'b0;
		end else begin
			rdata_q     <= rdata_d;
			presc_rst_q <= minutes_seconds_register_lo_wr;
		end
	end

	assign rdata_o           = rdata_q;
	assign module_on_o       = cfg_on_q;
	assign clock_output_on_o = cfg_oe_q;
	assign ref_source_o      = pwr_q[SRC_LSB +: PTR_W];
	assign drift_trim_o      = trim_q;
	assign write_unlock_o    = cfg_unlock_q;
	assign prescaler_reset_o = presc_rst_q;

endmodule : rtcw_top

// ### verif/rtcw_top_sva.sv
// port-level checks on the rtc register front end
`timescale 1ns/1ps
module rtcw_top_chk
	import rtcw_pkg::*;
#(
	parameter int WIN_CYC = UNLOCK_WIN_CYC
) (
	input wire logic              sys_clk_i,
	input wire logic              reset_n_i,
	input wire logic              other_reset_n_i,
	input wire logic [ADDR_W-1:0] addr_i,
	input wire logic [DATA_W-1:0] wdata_i,
	input wire logic [1:0]        be_i,
	input wire logic              wr_i,
	input wire logic              rd_i,
	input wire logic [DATA_W-1:0] rdata_o,
	input wire logic              module_on_o,
	input wire logic              clock_output_on_o,
	input wire logic [PTR_W-1:0]  ref_source_o,
	input wire logic [TRIM_W-1:0] drift_trim_o,
	input wire logic              write_unlock_o
);
	logic [3:0] since_aa_q;
	logic [3:0] since_aa_d;
	// decoded strobes of interest
	wire logic cfg_wr = wr_i && addr_i == ADDR_CFG;
	wire logic aa_wr = wr_i && addr_i == ADDR_KEY && be_i[0]
		&& wdata_i[7:0] == KEY_SECOND;
	wire logic dead_rd = rd_i && addr_i >= ADDR_KEY;
	// cycles since the second key byte; saturates so it never wraps open
	assign since_aa_d = aa_wr ? 4'h0 : since_aa_q + {3'h0, since_aa_q != 4'hf};
	always_ff @(posedge sys_clk_i) begin
		if (!reset_n_i)
			since_aa_q <= 4'hf;
		else
			since_aa_q <= since_aa_d;
	end
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!reset_n_i);
	AST_ON_LOCKED: assert property (cfg_wr && be_i[1] && !write_unlock_o
		|=> $stable(module_on_o)) else $error("enable moved while locked");
	AST_ON_OPEN: assert property (cfg_wr && be_i[1] && write_unlock_o
		&& wdata_i[CFG_UNLOCK_BIT] |=> module_on_o == $past(wdata_i[CFG_ON_BIT]))
		else $error("enable not written while unlocked");
	AST_OE_WRITE: assert property (cfg_wr && be_i[1]
		|=> clock_output_on_o == $past(wdata_i[CFG_OE_BIT]))
		else $error("output enable not written");
	AST_TRIM_WRITE: assert property (cfg_wr && be_i[0]
		|=> drift_trim_o == $past(wdata_i[7:0])) else $error("trim not written");
	AST_SRC_WRITE: assert property (wr_i && addr_i == ADDR_PWR && be_i[1]
		|=> ref_source_o == $past(wdata_i[11:10])) else $error("source wrong");
	AST_UNLOCK_KEY: assert property ($rose(write_unlock_o)
		|-> since_aa_q <= WIN_CYC && $past(cfg_wr)) else $error("unlock opened");
	AST_PWR_LOW: assert property (rd_i && addr_i == ADDR_PWR
		|=> rdata_o[7:0] == 8'h00) else $error("power low byte not zero");
	AST_DEAD_READ: assert property (dead_rd |=> rdata_o == 16'h0000)
		else $error("unmapped read not zero");
	AST_OTHER_RST: assert property (!other_reset_n_i && !wr_i
		|=> $stable(module_on_o) && $stable(drift_trim_o)
		&& $stable(clock_output_on_o)) else $error("config hit by reset");
endmodule : rtcw_top_chk

bind rtcw_top rtcw_top_chk #(.WIN_CYC(WIN_CYC)) u_chk (
	.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
	.other_reset_n_i(other_reset_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
	.be_i(be_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
	.module_on_o(module_on_o), .clock_output_on_o(clock_output_on_o),
	.ref_source_o(ref_source_o), .drift_trim_o(drift_trim_o),
	.write_unlock_o(write_unlock_o));

// ### verif/test_rtcw_top.sv
// self-checking bench for the rtc register front end
`timescale 1ns/1ps
module test_rtcw_top;
	import rtcw_pkg::*;
	typedef struct {
		logic [ADDR_W-1:0] a;
		logic [DATA_W-1:0] d;
		logic [DATA_W-1:0] e;
	} rtcw_row_s;
	logic sys_clk_i, reset_n_i, other_reset_n_i, wr_i, rd_i, ripple_i;
	logic half_tick_i, time_upd_we_i, module_on_o, clock_output_on_o;
	logic write_unlock_o, prescaler_reset_o;
	logic [ADDR_W-1:0] addr_i;
	logic [DATA_W-1:0] wdata_i, rdata_o, time_upd_data_i, got, prv;
	logic [1:0]        be_i;
	logic [PTR_W-1:0]  time_upd_sel_i, ref_source_o;
	logic [TRIM_W-1:0] drift_trim_o;
	int                n_errors, n_checks, cyc;
	// write then read back; locked enable and read-only bits stay zero
	rtcw_row_s rows [8] = '{'{ADDR_CFG, 16'hffff, 16'h07ff},
		'{ADDR_CFG, 16'h0000, 16'h0000}, '{ADDR_PWR, 16'hffff, 16'hff00},
		'{ADDR_PWR, 16'h0000, 16'h0000}, '{ADDR_ALSET, 16'hfcff, 16'hfcff},
		'{ADDR_KEY, 16'h0055, 16'h0000}, '{3'h6, 16'hffff, 16'h0000},
		'{3'h7, 16'hffff, 16'h0000}};

	rtcw_top #(.WIN_CYC(2)) uut (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
		.other_reset_n_i(other_reset_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.be_i(be_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
		.ripple_i(ripple_i), .half_tick_i(half_tick_i),
		.time_upd_we_i(time_upd_we_i), .time_upd_sel_i(time_upd_sel_i),
		.time_upd_data_i(time_upd_data_i), .module_on_o(module_on_o),
		.clock_output_on_o(clock_output_on_o), .ref_source_o(ref_source_o),
		.drift_trim_o(drift_trim_o), .write_unlock_o(write_unlock_o),
		.prescaler_reset_o(prescaler_reset_o));

	// one strobe cycle; read data is captured in the cycle after it
	task automatic acc(input logic w, input logic [ADDR_W-1:0] a,
		input logic [DATA_W-1:0] d, input logic [1:0] b);
		@(posedge sys_clk_i);
		wr_i <= w;
		rd_i <= !w;
		addr_i <= a;
		wdata_i <= d;
		be_i <= b;
		@(posedge sys_clk_i);
		wr_i <= 1'b0;
		rd_i <= 1'b0;
		#1;
		got = rdata_o;
	endtask : acc

	task automatic chk(input string n, input logic [DATA_W-1:0] g,
		input logic [DATA_W-1:0] e);
		n_checks++;
		if (g !== e) begin
			n_errors++;
			$display("unexpected %s: expected %h seen %h", n, e, g);
		end
	endtask : chk

	task automatic unlock_seq(input int gap);
		acc(1'b1, ADDR_KEY, 16'h0055, 2'h1);
		acc(1'b1, ADDR_KEY, 16'h00aa, 2'h1);
		repeat (gap) @(posedge sys_clk_i);
		acc(1'b1, ADDR_CFG, 16'ha300, 2'h3);
	endtask : unlock_seq

	task automatic end_of_test;
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : end_of_test

	// expected time pair: reserved high byte of slot 3 reads zero
	function automatic logic [DATA_W-1:0] tslot(input int s);
		tslot = (s == 3) ? 16'h0023 : 16'(16'h1020 + 16'h0101 * s);
	endfunction : tslot

	initial begin
		sys_clk_i = 1'b0;
		forever #5 sys_clk_i = ~sys_clk_i;
	end

	// hang guard; the sequence needs well under a thousand cycles
	always @(posedge sys_clk_i) begin
		cyc++;
		if (cyc == 3000) begin
			n_errors++;
			end_of_test();
		end
	end

	initial begin
		{reset_n_i, other_reset_n_i, wr_i, rd_i, ripple_i, half_tick_i} = '0;
		{time_upd_we_i, addr_i, wdata_i, be_i} = '0;
		{time_upd_sel_i, time_upd_data_i} = '0;
		other_reset_n_i = 1'b1;
		repeat (20) @(posedge sys_clk_i);
		reset_n_i <= 1'b1;
		@(posedge sys_clk_i);
		#1;
		chk("outputs at reset", 16'({module_on_o, write_unlock_o}), 16'h0);
		foreach (rows[i]) begin
			acc(1'b1, rows[i].a, rows[i].d, 2'h3);
			acc(1'b0, rows[i].a, '0, 2'h0);
			chk("table read", got, rows[i].e);
		end
		for (int s = 0; s < 4; s++) begin
			acc(1'b1, ADDR_PWR, 16'(s << SRC_LSB), 2'h3);
			chk("source", 16'(ref_source_o), 16'(s));
		end
		$display("done: register table");
		for (int s = 0; s < 4; s++) begin
			@(posedge sys_clk_i);
			time_upd_we_i <= 1'b1;
			time_upd_sel_i <= 2'(s);
			time_upd_data_i <= tslot(s);
		end
		@(posedge sys_clk_i);
		time_upd_we_i <= 1'b0;
		acc(1'b1, ADDR_CFG, 16'h0300, 2'h3);
		for (int k = 3; k >= -1; k--) begin
			acc(1'b0, ADDR_TIME, '0, 2'h0);
			chk("time window", got, tslot(k < 0 ? 0 : k));
		end
		acc(1'b1, ADDR_CFG, 16'h0300, 2'h3);
		acc(1'b1, ADDR_TIME, 16'habcd, 2'h3);
		acc(1'b0, ADDR_CFG, '0, 2'h0);
		chk("locked pointer", 16'(got[9:8]), 16'h3);
		acc(1'b0, ADDR_TIME, '0, 2'h0);
		chk("locked data", got, tslot(3));
		$display("done: time window");
		// a strobe between the two key bytes must spoil the sequence
		acc(1'b1, ADDR_KEY, 16'h0055, 2'h1);
		acc(1'b0, ADDR_CFG, '0, 2'h0);
		acc(1'b1, ADDR_KEY, 16'h00aa, 2'h1);
		acc(1'b1, ADDR_CFG, 16'ha300, 2'h3);
		chk("aborted key", 16'({module_on_o, write_unlock_o}), 16'h0);
		unlock_seq(3);
		chk("late set", 16'({module_on_o, write_unlock_o}), 16'h0);
		unlock_seq(0);
		chk("unlock only", 16'({module_on_o, write_unlock_o}), 16'h1);
		acc(1'b1, ADDR_CFG, 16'ha300, 2'h3);
		chk("unlock", 16'({module_on_o, write_unlock_o}), 16'h3);
		$display("done: unlock");
		acc(1'b1, ADDR_TIME, 16'h5a5a, 2'h3);
		acc(1'b1, ADDR_TIME, 16'h00c3, 2'h1);
		acc(1'b0, ADDR_CFG, '0, 2'h0);
		chk("high write step", 16'(got[9:8]), 16'h2);
		acc(1'b0, ADDR_TIME, '0, 2'h0);
		chk("low write data", got, 16'h12c3);
		acc(1'b1, ADDR_TIME, 16'h4400, 2'h2);
		acc(1'b1, ADDR_TIME, 16'h5500, 2'h2);
		acc(1'b0, ADDR_CFG, '0, 2'h0);
		chk("pointer floor", 16'(got[9:8]), 16'h0);
		@(posedge sys_clk_i);
		half_tick_i <= 1'b1;
		@(posedge sys_clk_i);
		half_tick_i <= 1'b0;
		acc(1'b0, ADDR_CFG, '0, 2'h0);
		chk("half set", 16'(got[CFG_HALF_BIT]), 16'h1);
		acc(1'b1, ADDR_TIME, 16'h0011, 2'h1);
		acc(1'b0, ADDR_CFG, '0, 2'h0);
		chk("half cleared", 16'(got[CFG_HALF_BIT]), 16'h0);
		@(posedge sys_clk_i);
		ripple_i <= 1'b1;
		repeat (2) @(posedge sys_clk_i);
		acc(1'b0, ADDR_CFG, '0, 2'h0);
		chk("ripple", 16'(got[CFG_RIPPLE_BIT]), 16'h1);
		// software reads twice while the flag is up and compares
		prv = got;
		acc(1'b0, ADDR_CFG, '0, 2'h0);
		chk("ripple reread", got, prv);
		ripple_i <= 1'b0;
		$display("done: unlocked writes");
		acc(1'b1, ADDR_ALSET, 16'h0300, 2'h3);
		for (int k = 0; k < 5; k++)
			acc(1'b1, ADDR_ALARM, 16'(16'h0101 * (k + 1)), 2'h3);
		acc(1'b1, ADDR_ALSET, 16'h0300, 2'h3);
		// slot 0 was written twice at the floor, so it holds the last word
		for (int k = 3; k >= -1; k--) begin
			acc(1'b0, ADDR_ALARM, '0, 2'h0);
			chk("alarm", got, k == 3 ? 16'h0
				: 16'(16'h0101 * (k > 0 ? 4 - k : 5)));
		end
		$display("done: alarm window");
		@(posedge sys_clk_i);
		other_reset_n_i <= 1'b0;
		repeat (2) @(posedge sys_clk_i);
		other_reset_n_i <= 1'b1;
		acc(1'b0, ADDR_ALSET, '0, 2'h0);
		chk("alarm setup reset", got, 16'h0);
		chk("config kept", 16'({module_on_o, write_unlock_o}), 16'h3);
		// software locks again once the time update is done
		acc(1'b1, ADDR_CFG, 16'h0000, 2'h2);
		chk("relocked", 16'({module_on_o, write_unlock_o}), 16'h0);
		reset_n_i <= 1'b0;
		repeat (2) @(posedge sys_clk_i);
		reset_n_i <= 1'b1;
		@(posedge sys_clk_i);
		#1;
		chk("power-on reset", 16'({module_on_o, drift_trim_o}), 16'h0);
		$display("done: resets");
		end_of_test();
	end
endmodule : test_rtcw_top
